// >>> dv/cpw_monitor.sv
// Checker for the complementary PWM generator, watching its top-level ports.
// Assumes one clock aclk and a synchronous active-low aresetn.
`timescale 1ns/100ps
module cpw_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire cpw_pkg::cpw_pair_t pwm_out,
    input wire logic trigger_event
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Both switches on shorts the supply, so overlap is never allowed
    a_no_overlap: assert property (!(pwm_out.high_side_out && pwm_out.low_side_out))
        else $error("both outputs high");
    // Reset has its own check, so the default disable is overridden
    a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> pwm_out == 2'h0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active after reset");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted during data");
    a_trig_pulse: assert property (trigger_event |=> !trigger_event)
        else $error("trigger longer than a cycle");
endmodule // cpw_monitor

bind cpw_gen cpw_monitor cpw_monitor_i (.*);

// >>> dv/cpw_stage.sv
// Model of the power stage behind the outputs, with its current-limit sense.
// Assumes the bench asks for a trip by pulsing trip for one clock.
`timescale 1ns/100ps
module cpw_stage (
    input wire logic aclk,
    input wire cpw_pkg::cpw_pair_t pwm_out,
    input wire logic trip,
    output logic current_limit
);
    logic [1:0] hold_r = 2'h0;
    // Two-clock sense pulse, short enough to count as one event
    always_ff @(posedge aclk) begin
        hold_r <= trip ? 2'h2 : hold_r - {1'b0, hold_r != 2'h0};
    end
    assign current_limit = hold_r != 2'h0;
endmodule // cpw_stage

// >>> dv/tb.sv
// Self-checking bench for the complementary PWM generator.
// Assumes the stage model drives current_limit; registers reached over AXI4-Lite.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_count++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module tb;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, trip = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, current_limit, trigger_event;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    cpw_pkg::cpw_pair_t pwm_out;
    int err_count = 0, checks_done = 0, g, m;
    always #25 aclk = ~aclk;
    cpw_gen cpw_gen_i (.*);
    cpw_stage cpw_stage_i (.aclk(aclk), .pwm_out(pwm_out), .trip(trip), .current_limit(current_limit));
    task automatic complete_run;
        $display("Counts: %0d checks, %0d mismatches", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic bail;
        err_count++;
        complete_run;
    endtask
    // Ready is sampled at the falling edge so the handshake edge sees settled values
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] r;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        b = 1'b0;
        for (int n = 0; n < 50 && !b; n++) begin
            @(negedge aclk);
            {aw, w, b, r} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end
        if (!b) bail;
        `CHK("bresp", er, r)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar, v;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        v = 1'b0;
        for (int n = 0; n < 50 && !v; n++) begin
            @(negedge aclk);
            {ar, v, d, r} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (v) s_axi_rready <= 1'b0;
        end
        if (!v) bail;
        `CHK("rdata", ed, d)
        `CHK("rresp", er, r)
    endtask
    task automatic cfg(input logic [15:0] c, input logic [15:0] ph, input logic [15:0] du, input logic [7:0] dt);
        wr(cpw_pkg::OFF_GEN_CTRL, 32'h0, 2'h0);
        wr(cpw_pkg::OFF_PHASE, {16'h0, ph}, 2'h0);
        wr(cpw_pkg::OFF_MASTER_PER, {16'h0, ph}, 2'h0);
        wr(cpw_pkg::OFF_DUTY, {16'h0, du}, 2'h0);
        wr(cpw_pkg::OFF_DEAD, {24'h0, dt}, 2'h0);
        wr(cpw_pkg::OFF_ALT_DEAD, {24'h0, dt + 8'h01}, 2'h0);
        wr(cpw_pkg::OFF_OUT_CTRL, 32'h0, 2'h0);
        wr(cpw_pkg::OFF_GEN_CTRL, {16'h0, c}, 2'h0);
    endtask
    task automatic wait_pair(input logic [1:0] e, input int lim);
        for (int n = 0; n < lim; n++) begin
            @(negedge aclk);
            if (pwm_out === e) return;
        end
        bail;
    endtask
    // Length of the next all-off gap; waits up to 60 cycles for both outputs low if not already
    task automatic gap(output int len);
        if (pwm_out !== 2'h0) wait_pair(2'h0, 60);
        for (len = 0; len < 60 && pwm_out === 2'h0; len++) @(negedge aclk);
    endtask
    task automatic steady(input logic [1:0] e, output logic ok);
        wait_pair(e, 60);
        ok = 1'b1;
        repeat (50) @(negedge aclk) ok &= pwm_out === e;
    endtask
    task automatic wait_trig(input int lim, output int cnt);
        for (cnt = 0; cnt < lim && trigger_event !== 1'b1; cnt++) @(negedge aclk);
    endtask
    task automatic t_regs;
        rd(cpw_pkg::OFF_PHASE, 32'h3E8, cpw_pkg::AXI_OKAY);
        rd(cpw_pkg::OFF_MASTER_PER, 32'h3E8, cpw_pkg::AXI_OKAY);
        wr(8'h40, 32'h1, cpw_pkg::AXI_SLVERR);
        rd(8'h40, 32'h0, cpw_pkg::AXI_SLVERR);
        wr(cpw_pkg::OFF_GEN_CTRL, 32'h0200, cpw_pkg::AXI_OKAY);
        rd(cpw_pkg::OFF_GEN_CTRL, 32'h0200, cpw_pkg::AXI_OKAY);
        wr(cpw_pkg::OFF_DUTY, 32'hFFFFABCD, cpw_pkg::AXI_OKAY);
        rd(cpw_pkg::OFF_DUTY, 32'h0000ABCD, cpw_pkg::AXI_OKAY);
        $display("t_regs done");
    endtask
    // Edge and center forms under both time bases, at both duty extremes
    task automatic t_full;
        logic ok;
        for (int i = 0; i < 4; i++) begin
            cfg(16'h8000 | (i[0] ? 16'h0200 : 16'h0) | (i[1] ? 16'h0004 : 16'h0), 16'd20, 16'd0, 8'd3);
            steady(2'h1, ok);
            `CHK("zero_duty", 1'b1, ok)
            wr(cpw_pkg::OFF_DUTY, 32'd20, 2'h0);
            steady(2'h2, ok);
            `CHK("full_duty", 1'b1, ok)
        end
        $display("t_full done");
    endtask
    task automatic t_edges;
        cfg(16'h8201, 16'd20, 16'd15, 8'd3);
        wait_pair(2'h1, 60);
        gap(g);
        `CHK("rise_gap", 3, g)
        wait_pair(2'h0, 60);
        gap(g);
        `CHK("fall_gap", 4, g)
        wait_pair(2'h2, 60);
        wr(cpw_pkg::OFF_DUTY, 32'd2, 2'h0);
        wait_pair(2'h0, 6);
        gap(g);
        `CHK("imm_gap", 4, g)
        $display("t_edges done");
    endtask
    task automatic t_ovr;
        logic ok;
        cfg(16'h8200, 16'd20, 16'd10, 8'd2);
        wr(cpw_pkg::OFF_OUT_CTRL, 32'h0341, 2'h0);
        steady(2'h1, ok);
        `CHK("ovr_zero", 1'b1, ok)
        wr(cpw_pkg::OFF_OUT_CTRL, 32'h0381, 2'h0);
        steady(2'h2, ok);
        `CHK("ovr_full", 1'b1, ok)
        $display("t_ovr done");
    endtask
    // Software route to the extremes: alternate dead time cleared (dead time too when edge-aligned), duty at zero or past the period
    task automatic t_sw_ext;
        logic ok;
        for (int i = 0; i < 2; i++) begin
            cfg(i[0] ? 16'h8204 : 16'h8200, 16'd20, 16'd0, 8'd3);
            wr(cpw_pkg::OFF_ALT_DEAD, 32'h0, 2'h0);
            if (!i[0]) wr(cpw_pkg::OFF_DEAD, 32'h0, 2'h0);
            steady(2'h1, ok);
            `CHK("sw_zero", 1'b1, ok)
            wr(cpw_pkg::OFF_DUTY, i[0] ? 32'd22 : 32'd21, 2'h0);
            steady(2'h2, ok);
            `CHK("sw_full", 1'b1, ok)
        end
        $display("t_sw_ext done");
    endtask
    // Trips come mid-cycle; the trigger at count zero shows the restart
    task automatic t_creset;
        for (int i = 0; i < 3; i++) begin
            cfg(i < 2 ? 16'h8202 : 16'h8002, 16'd40, 16'd20, 8'd1);
            wr(cpw_pkg::OFF_TRIG, 32'h0, 2'h0);
            repeat (2) begin
                wait_trig(100, m);
                if (m >= 100) bail;
                repeat (10) @(posedge aclk);
                trip <= 1'b1;
                @(posedge aclk);
                trip <= 1'b0;
                wait_trig(8, m);
                `CHK("restart", i < 2, m < 8)
            end
        end
        $display("t_creset done");
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_full;
        t_edges;
        t_ovr;
        t_sw_ext;
        t_creset;
        complete_run;
    end
endmodule // tb

// >>> logic/cpw_gen.sv
// Complementary PWM generator: time base, duty compare, dead time, override, current reset.
// Assumes one clock aclk, synchronous active-low aresetn, and AXI4-Lite for registers.
// Summary of operation
// - Complementary output from independent or master time base, with optional immediate duty update.
// - Center-aligned and edge-aligned forms work under either time base.
// - Immediate update with count between old and new duty switches the outputs at once.
// - Dead time is inserted on every complementary edge, including immediate-update edges.
// - Duty zero with non-zero dead time keeps the low side on for the whole period.
// - Duty at or past the period (phase value, or master period on the master base) with non-zero dead time keeps the high side on for the whole period.
// - Both override enables with sync set force outputs from override levels; 01 is 0%, 10 is 100%.
// - Generator control bit 1 selects current reset, where a current-limit event restarts the cycle of the independent time base only.
// - Generator control bit 9 selects independent time base, cleared follows the master.
// - Current reset with independent time base restarts on every qualifying cycle.
`timescale 1ns/100ps
module cpw_gen #(
    parameter int unsigned CNT_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic current_limit,
    output cpw_pkg::cpw_pair_t pwm_out,
    output logic trigger_event
);
    // Register merge and status word are laid out for the package width only
    if (CNT_W != cpw_pkg::CW) begin : g_width_check
        $error("cpw_gen: CNT_W must equal package width");
    end

    logic [15:0] generator_control_r;
    logic [CNT_W-1:0] duty_value_r;
    logic [CNT_W-1:0] phase_value_r;
    logic [CNT_W-1:0] dead_time_value_r;
    logic [CNT_W-1:0] alternate_dead_time_value_r;
    logic [15:0] output_control_r;
    logic [CNT_W-1:0] trigger_compare_value_r;
    logic [CNT_W-1:0] master_period_r;
    logic [CNT_W-1:0] active_duty_r;
    logic [CNT_W-1:0] own_cnt_r;
    logic own_down_r;
    logic [CNT_W-1:0] mst_cnt_r;
    logic [CNT_W-1:0] dt_cnt_r;
    logic raw_r;
    logic raw_nxt;
    logic hi_r;
    logic lo_r;
    logic [1:0] ovr_act_r;
    logic [1:0] ovr_dat_r;
    logic cl_prev_r;

    // Control field views
    logic en;
    logic imm;
    logic cur_rst;
    logic center;
    logic independent_timebase_select;
    assign en = generator_control_r[cpw_pkg::GC_ENABLE];
    assign imm = generator_control_r[cpw_pkg::GC_IMM_UPD];
    assign cur_rst = generator_control_r[cpw_pkg::GC_CUR_RESET];
    assign center = generator_control_r[cpw_pkg::GC_CENTER];
    assign independent_timebase_select = generator_control_r[cpw_pkg::GC_ITB];

    // AXI4-Lite write path: address and data taken in either order
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_go;
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign wr_go = aw_held_r && w_held_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= cpw_pkg::AXI_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_r[1:0] == 2'h0 && aw_addr_r <= cpw_pkg::OFF_MASTER_PER)
                    ? cpw_pkg::AXI_OKAY : cpw_pkg::AXI_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [15:0] r;
        r = old;
        if (s[0]) r[7:0] = d[7:0];
        if (s[1]) r[15:8] = d[15:8];
        return r;
    endfunction

    // Register stores
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            generator_control_r <= 16'h0000;
            duty_value_r <= '0;
            phase_value_r <= cpw_pkg::RST_PHASE;
            dead_time_value_r <= '0;
            alternate_dead_time_value_r <= '0;
            output_control_r <= 16'h0000;
            trigger_compare_value_r <= '0;
            master_period_r <= cpw_pkg::RST_MASTER_PER;
        end else if (wr_go) begin
            unique case (aw_addr_r)
                cpw_pkg::OFF_GEN_CTRL: generator_control_r <= merge16(generator_control_r, w_data_r, w_strb_r);
                cpw_pkg::OFF_DUTY: duty_value_r <= merge16(duty_value_r, w_data_r, w_strb_r);
                cpw_pkg::OFF_PHASE: phase_value_r <= merge16(phase_value_r, w_data_r, w_strb_r);
                cpw_pkg::OFF_DEAD: dead_time_value_r <= merge16(dead_time_value_r, w_data_r, w_strb_r);
                cpw_pkg::OFF_ALT_DEAD:
                    alternate_dead_time_value_r <= merge16(alternate_dead_time_value_r, w_data_r, w_strb_r);
                cpw_pkg::OFF_OUT_CTRL: output_control_r <= merge16(output_control_r, w_data_r, w_strb_r);
                cpw_pkg::OFF_TRIG: trigger_compare_value_r <= merge16(trigger_compare_value_r, w_data_r, w_strb_r);
                cpw_pkg::OFF_MASTER_PER: master_period_r <= merge16(master_period_r, w_data_r, w_strb_r);
                default: ;
            endcase
        end
    end

    // AXI4-Lite read path, one outstanding read
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= cpw_pkg::AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= cpw_pkg::AXI_OKAY;
            unique case (s_axi_araddr)
                cpw_pkg::OFF_GEN_CTRL: s_axi_rdata <= {16'h0000, generator_control_r};
                cpw_pkg::OFF_DUTY: s_axi_rdata <= {16'h0000, duty_value_r};
                cpw_pkg::OFF_PHASE: s_axi_rdata <= {16'h0000, phase_value_r};
                cpw_pkg::OFF_DEAD: s_axi_rdata <= {16'h0000, dead_time_value_r};
                cpw_pkg::OFF_ALT_DEAD: s_axi_rdata <= {16'h0000, alternate_dead_time_value_r};
                cpw_pkg::OFF_OUT_CTRL: s_axi_rdata <= {16'h0000, output_control_r};
                cpw_pkg::OFF_TRIG: s_axi_rdata <= {16'h0000, trigger_compare_value_r};
                cpw_pkg::OFF_MASTER_PER: s_axi_rdata <= {16'h0000, master_period_r};
                // Live state: own counter, direction and output levels
                cpw_pkg::OFF_STATUS: s_axi_rdata <= {13'h0000, own_down_r, hi_r, lo_r, own_cnt_r};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= cpw_pkg::AXI_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Current-limit rising edge; acts every cycle it occurs, not alternate ones
    logic cl_event;
    assign cl_event = cur_rst && independent_timebase_select && current_limit && !cl_prev_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) cl_prev_r <= 1'b0;
        else cl_prev_r <= current_limit;
    end

    // Master time base; up/down when center-aligned, so both forms work on it too
    logic mst_down_r;
    logic mst_end;
    assign mst_end = mst_down_r ? (mst_cnt_r == '0) : (mst_cnt_r >= master_period_r);
    always_ff @(posedge aclk) begin
        if (!aresetn || !en) begin
            mst_cnt_r <= '0;
            mst_down_r <= 1'b0;
        end else if (center) begin
            if (mst_end) begin
                mst_down_r <= !mst_down_r;
                mst_cnt_r <= mst_down_r ? mst_cnt_r + 1'b1 : mst_cnt_r - 1'b1;
            end else begin
                mst_cnt_r <= mst_down_r ? mst_cnt_r - 1'b1 : mst_cnt_r + 1'b1;
            end
        end else begin
            mst_down_r <= 1'b0;
            mst_cnt_r <= mst_end ? '0 : mst_cnt_r + 1'b1;
        end
    end

    // Independent time base; period is the phase value, up/down when center-aligned
    logic own_end;
    assign own_end = own_down_r ? (own_cnt_r == '0) : (own_cnt_r >= phase_value_r);
    always_ff @(posedge aclk) begin
        if (!aresetn || !en || cl_event) begin
            own_cnt_r <= '0;
            own_down_r <= 1'b0;
        end else if (center) begin
            if (own_end) begin
                own_down_r <= !own_down_r;
                own_cnt_r <= own_down_r ? own_cnt_r + 1'b1 : own_cnt_r - 1'b1;
            end else begin
                own_cnt_r <= own_down_r ? own_cnt_r - 1'b1 : own_cnt_r + 1'b1;
            end
        end else begin
            own_down_r <= 1'b0;
            own_cnt_r <= own_end ? '0 : own_cnt_r + 1'b1;
        end
    end

    // Time base select and period boundary
    logic [CNT_W-1:0] tb;
    logic boundary;
    assign tb = independent_timebase_select ? own_cnt_r : mst_cnt_r;
    assign boundary = independent_timebase_select ? (own_end && (!center || own_down_r)) : (mst_end && (!center || mst_down_r));

    // Active duty: immediate write or load at period boundary
    always_ff @(posedge aclk) begin
        if (!aresetn) active_duty_r <= '0;
        else if (imm || boundary) active_duty_r <= duty_value_r;
    end

    // Raw compare; 0 gives low all period, duty at or past the last count gives high all period
    logic [CNT_W-1:0] per_end;
    assign per_end = independent_timebase_select ? phase_value_r : master_period_r;
    always_comb begin
        raw_nxt = (tb < active_duty_r) || (active_duty_r >= per_end);
    end

    // Dead time: the rising side waits out the count after every raw edge
    logic [CNT_W-1:0] dt_sel;
    assign dt_sel = raw_nxt ? dead_time_value_r : alternate_dead_time_value_r;
    always_ff @(posedge aclk) begin
        if (!aresetn || !en) begin
            raw_r <= 1'b0;
            dt_cnt_r <= '0;
        end else begin
            raw_r <= raw_nxt;
            if (raw_nxt != raw_r) dt_cnt_r <= dt_sel;
            else if (dt_cnt_r != '0) dt_cnt_r <= dt_cnt_r - 1'b1;
        end
    end

    // Outputs before override; a steady level never loses its side
    always_ff @(posedge aclk) begin
        if (!aresetn || !en) begin
            hi_r <= 1'b0;
            lo_r <= 1'b0;
        end else if (raw_nxt != raw_r) begin
            // Zero dead time hands over at once; otherwise both sides drop first
            hi_r <= raw_nxt && (dt_sel == '0);
            lo_r <= !raw_nxt && (dt_sel == '0);
        end else begin
            // Count of one left means the programmed number of off cycles has passed
            hi_r <= raw_r && (dt_cnt_r[CNT_W-1:1] == '0);
            lo_r <= !raw_r && (dt_cnt_r[CNT_W-1:1] == '0);
        end
    end

    // Override latch: sync set waits for the period boundary to avoid runt pulses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovr_act_r <= 2'b00;
            ovr_dat_r <= 2'b00;
        end else if (!output_control_r[cpw_pkg::OC_SYNC] || boundary) begin
            ovr_act_r <= {output_control_r[cpw_pkg::OC_OVR_H], output_control_r[cpw_pkg::OC_OVR_L]};
            ovr_dat_r <= {output_control_r[cpw_pkg::OC_DAT_H], output_control_r[cpw_pkg::OC_DAT_L]};
        end
    end

    // Output drive, from flip-flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_out <= '0;
            trigger_event <= 1'b0;
        end else begin
            pwm_out.high_side_out <= ovr_act_r[1] ? ovr_dat_r[1] : hi_r;
            pwm_out.low_side_out <= ovr_act_r[0] ? ovr_dat_r[0] : lo_r;
            // Pulse for timing duty writes safely
            trigger_event <= en && (tb == trigger_compare_value_r);
        end
    end
endmodule // cpw_gen

// >>> logic/cpw_pkg.sv
// Package for the complementary PWM generator with dead time.
// Assumes a single 20 MHz clock domain and an AXI4-Lite register slave.
package cpw_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned CW = 16;
    // Register byte offsets
    localparam logic [7:0] OFF_GEN_CTRL = 8'h00;
    localparam logic [7:0] OFF_DUTY = 8'h04;
    localparam logic [7:0] OFF_PHASE = 8'h08;
    localparam logic [7:0] OFF_DEAD = 8'h0C;
    localparam logic [7:0] OFF_ALT_DEAD = 8'h10;
    localparam logic [7:0] OFF_OUT_CTRL = 8'h14;
    localparam logic [7:0] OFF_TRIG = 8'h18;
    localparam logic [7:0] OFF_MASTER_PER = 8'h1C;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    // Generator control fields
    localparam int unsigned GC_IMM_UPD = 0;
    localparam int unsigned GC_CUR_RESET = 1;
    localparam int unsigned GC_CENTER = 2;
    localparam int unsigned GC_ENABLE = 15;
    localparam int unsigned GC_ITB = 9;
    // Output control fields
    localparam int unsigned OC_SYNC = 0;
    localparam int unsigned OC_OVR_L = 8;
    localparam int unsigned OC_OVR_H = 9;
    localparam int unsigned OC_DAT_L = 6;
    localparam int unsigned OC_DAT_H = 7;
    // Reset values
    localparam logic [CW-1:0] RST_PHASE = 16'h03E8;
    localparam logic [CW-1:0] RST_MASTER_PER = 16'h03E8;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef struct packed {
        logic high_side_out;
        logic low_side_out;
    } cpw_pair_t;

    typedef enum logic [1:0] {
        CPW_ST_IDLE,
        CPW_ST_RESP
    } cpw_bus_st_t;
endpackage
